// *** hw/ffcl_pkg.sv ***
// Package of offsets, fields and reset values for the fault flag and config lock block
package ffcl_pkg;
   // Register indices; the APB byte address is four times the index
   localparam logic [7:0] ADDR_THRESH_CFG = 8'h0C;
   localparam logic [7:0] ADDR_WR_DISABLE = 8'h43;
   localparam logic [7:0] ADDR_CFG_LOCK   = 8'h45;
   localparam logic [7:0] ADDR_PRI_FAULT  = 8'h60;
   localparam logic [7:0] ADDR_SEC_FAULT  = 8'h61;
   localparam logic [7:0] ADDR_EVT_FAULT  = 8'h62;
   localparam logic [7:0] ADDR_IRQ_STAT   = 8'h70;
   localparam logic [7:0] ADDR_IRQ_MASK   = 8'h74;
   localparam logic [7:0] ADDR_EE_STAT    = 8'h78;
   // Field positions
   localparam int LOCK_BIT      = 0;
   localparam int EVT_WDOG_LO   = 0;
   localparam int EVT_GEN_LO    = 2;
   localparam int EVT_MR_BIT    = 6;
   localparam int IRQ_FAULT_BIT = 0;
   localparam int IRQ_BLOCK_BIT = 1;
   localparam int IRQ_WD_BIT    = 2;
   // Reset values
   localparam logic [7:0] RST_THRESH_CFG = 8'h00;
   localparam logic [7:0] RST_WR_DISABLE = 8'h00;
   localparam logic [7:0] RST_CFG_LOCK   = 8'h00;
   localparam logic [2:0] RST_IRQ_MASK   = 3'h0;
   // Widths
   localparam int NUM_RAILS = 6;
   localparam int NUM_PO    = 8;
   localparam int NUM_WDOG  = 2;
   localparam int NUM_GEN   = 4;
   localparam int NUM_IRQ   = 3;
   // APB error answer for unmapped address
   localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
endpackage : ffcl_pkg

// *** hw/ffcl_flag_bank.sv ***
// Sticky fault flag register with set-over-clear
`timescale 1ns/10ps
module ffcl_flag_bank #(
   parameter int WIDTH = 8
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] set_in,
   input  wire logic             clear,
   output logic      [WIDTH-1:0] flags
);
   ////////////////////////////////////////////////////////////
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               flags[i] <= 1'b0;
            end else if (set_in[i]) begin
               flags[i] <= 1'b1;
            end else if (clear) begin
               flags[i] <= 1'b0;
            end
         end
      end
   endgenerate
endmodule : ffcl_flag_bank

// *** hw/ffcl_top.sv ***
// Fault flag bank and configuration lock with APB access
//
// The implementer's own choice: the APB register port.
`timescale 1ns/10ps
module ffcl_top (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [9:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [5:0]  pri_under,
   input  wire logic [5:0]  sec_under,
   input  wire logic [5:0]  sec_over,
   input  wire logic [1:0]  watchdog_timeout,
   input  wire logic [1:0]  watchdog_pulse_input_sel,
   input  wire logic [1:0]  watchdog_on_general,
   input  wire logic [3:0]  general_input,
   input  wire logic        manual_reset_input,
   input  wire logic [7:0]  programmable_output,
   input  wire logic        ee_wr_req,
   output logic             ee_wr_en,
   output logic             ee_wr_blocked,
   output logic             cfg_locked,
   output logic [7:0]       thresh_cfg,
   output logic [7:0]       wr_disable,
   output logic             irq
);
   ////////////////////////////////////////////////////////////
   // Decode helpers
   function automatic logic hit(input logic [9:0] a, input logic [7:0] b);
      hit = (a[9:2] == b);
   endfunction : hit

   function automatic logic is_fault(input logic [9:0] a);
      is_fault = hit(a, ffcl_pkg::ADDR_PRI_FAULT) | hit(a, ffcl_pkg::ADDR_EVT_FAULT)
                 | hit(a, ffcl_pkg::ADDR_SEC_FAULT);
   endfunction : is_fault

   ////////////////////////////////////////////////////////////
   // Bus phases
   logic       wr_acc;
   logic       rd_acc;
   logic       mapped;
   logic [9:0] pa;

   // Byte address is four times the register index
   assign pa       = paddr;
   assign wr_acc   = psel & penable & pready & pwrite;
   assign rd_acc   = psel & penable & pready & ~pwrite;
   assign mapped   = hit(pa, ffcl_pkg::ADDR_THRESH_CFG) | hit(pa, ffcl_pkg::ADDR_WR_DISABLE)
                   | hit(pa, ffcl_pkg::ADDR_CFG_LOCK) | is_fault(pa)
                   | hit(pa, ffcl_pkg::ADDR_IRQ_STAT) | hit(pa, ffcl_pkg::ADDR_IRQ_MASK)
                   | hit(pa, ffcl_pkg::ADDR_EE_STAT);

   // One wait state: ready in the second access cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pready <= 1'b0;
      end else begin
         pready <= psel & penable & ~pready;
      end
   end

   ////////////////////////////////////////////////////////////
   // Fault detection
   logic [5:0] sec_hit;
   logic [7:0] pri_set;
   logic [7:0] sec_set;
   logic [7:0] evt_set;
   logic [1:0] wd_gen_hit;
   logic [3:0] gen_from_wd;
   logic       fault_clear;
   logic [7:0] pri_flags;
   logic [7:0] sec_flags;
   logic [7:0] evt_flags;

   assign sec_hit = (thresh_cfg[5:0] & sec_over) | (~thresh_cfg[5:0] & sec_under);

   // Watchdog also flags its general input
   // One selector serves both watchdogs
   genvar g;
   generate
      for (g = 0; g < ffcl_pkg::NUM_GEN; g++) begin : g_wdgen
         assign gen_from_wd[g] = (|wd_gen_hit) & (watchdog_pulse_input_sel == 2'(g));
      end
   endgenerate
   assign wd_gen_hit = watchdog_timeout & watchdog_on_general;

   assign pri_set = {2'b00, pri_under};
   assign sec_set = {2'b00, sec_hit};
   assign evt_set = {1'b0, manual_reset_input, general_input | gen_from_wd, watchdog_timeout};

   assign fault_clear = rd_acc & is_fault(pa);

   ffcl_flag_bank #(.WIDTH(8)) u_pri (
      .clk    (clk),
      .rst_n  (rst_n),
      .set_in (pri_set),
      .clear  (fault_clear),
      .flags  (pri_flags)
   );
   ffcl_flag_bank #(.WIDTH(8)) u_sec (
      .clk    (clk),
      .rst_n  (rst_n),
      .set_in (sec_set),
      .clear  (fault_clear),
      .flags  (sec_flags)
   );
   ffcl_flag_bank #(.WIDTH(8)) u_evt (
      .clk    (clk),
      .rst_n  (rst_n),
      .set_in (evt_set),
      .clear  (fault_clear),
      .flags  (evt_flags)
   );

   // First fault read after reset recorded in first_read_done
   logic first_read_done;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         first_read_done <= 1'b0;
      end else if (fault_clear) begin
         first_read_done <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////
   // Configuration registers
   logic       cfg_wr_ok;
   logic       ee_block;
   logic [2:0] irq_stat;
   logic [2:0] irq_mask;
   logic [2:0] irq_evt;

   assign cfg_wr_ok = wr_acc & ~cfg_locked;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         thresh_cfg <= ffcl_pkg::RST_THRESH_CFG;
      end else if (cfg_wr_ok && hit(pa, ffcl_pkg::ADDR_THRESH_CFG)) begin
         thresh_cfg <= pwdata[7:0];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_disable <= ffcl_pkg::RST_WR_DISABLE;
      end else if (cfg_wr_ok && hit(pa, ffcl_pkg::ADDR_WR_DISABLE)) begin
         wr_disable <= pwdata[7:0];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_locked <= ffcl_pkg::RST_CFG_LOCK[ffcl_pkg::LOCK_BIT];
      end else if (wr_acc && hit(pa, ffcl_pkg::ADDR_CFG_LOCK)) begin
         cfg_locked <= pwdata[ffcl_pkg::LOCK_BIT];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_mask <= ffcl_pkg::RST_IRQ_MASK;
      end else if (wr_acc && hit(pa, ffcl_pkg::ADDR_IRQ_MASK)) begin
         irq_mask <= pwdata[2:0];
      end
   end

   ////////////////////////////////////////////////////////////
   // EEPROM write gating
   // Per-output write disable
   // Suppress writes while guarded outputs assert
   assign ee_block = |(wr_disable & programmable_output) | cfg_locked;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ee_wr_en      <= 1'b0;
         ee_wr_blocked <= 1'b0;
      end else begin
         ee_wr_en      <= ee_wr_req & ~ee_block;
         ee_wr_blocked <= ee_wr_req & ee_block;
      end
   end

   ////////////////////////////////////////////////////////////
   // Interrupts
   assign irq_evt[ffcl_pkg::IRQ_FAULT_BIT] = |{pri_set, sec_set, evt_set};
   assign irq_evt[ffcl_pkg::IRQ_BLOCK_BIT] = ee_wr_req & ee_block;
   assign irq_evt[ffcl_pkg::IRQ_WD_BIT]    = |watchdog_timeout;

   genvar k;
   generate
      for (k = 0; k < ffcl_pkg::NUM_IRQ; k++) begin : g_irq
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               irq_stat[k] <= 1'b0;
            end else if (irq_evt[k]) begin
               irq_stat[k] <= 1'b1;
            end else if (wr_acc && hit(pa, ffcl_pkg::ADDR_IRQ_STAT) && pwdata[k]) begin
               irq_stat[k] <= 1'b0;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_stat & irq_mask);
      end
   end

   ////////////////////////////////////////////////////////////
   // Read data and error
   logic [31:0] next_prdata;
   always_comb begin
      next_prdata = ffcl_pkg::RD_UNMAPPED;
      if (hit(pa, ffcl_pkg::ADDR_THRESH_CFG)) begin
         next_prdata = {24'h000000, thresh_cfg};
      end else if (hit(pa, ffcl_pkg::ADDR_WR_DISABLE)) begin
         next_prdata = {24'h000000, wr_disable};
      end else if (hit(pa, ffcl_pkg::ADDR_CFG_LOCK)) begin
         next_prdata = {31'h00000000, cfg_locked};
      end else if (hit(pa, ffcl_pkg::ADDR_PRI_FAULT)) begin
         next_prdata = {24'h000000, pri_flags};
      end else if (hit(pa, ffcl_pkg::ADDR_SEC_FAULT)) begin
         next_prdata = {24'h000000, sec_flags};
      end else if (hit(pa, ffcl_pkg::ADDR_EVT_FAULT)) begin
         next_prdata = {24'h000000, evt_flags};
      end else if (hit(pa, ffcl_pkg::ADDR_IRQ_STAT)) begin
         next_prdata = {29'h00000000, irq_stat};
      end else if (hit(pa, ffcl_pkg::ADDR_IRQ_MASK)) begin
         next_prdata = {29'h00000000, irq_mask};
      end else if (hit(pa, ffcl_pkg::ADDR_EE_STAT)) begin
         next_prdata = {30'h00000000, first_read_done, ee_block};
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end else begin
         prdata  <= (psel & penable & ~pready & ~pwrite) ? next_prdata : 32'h00000000;
         pslverr <= psel & penable & ~pready & ~mapped;
      end
   end

   ////////////////////////////////////////////////////////////
   // Checks
   // Locked config frozen
   lock_holds_a: assert property (@(posedge clk) disable iff (!rst_n)
      $past(cfg_locked) |-> $stable(thresh_cfg) && $stable(wr_disable))
      else $error("config changed while locked");
   read_clears_a: assert property (@(posedge clk) disable iff (!rst_n)
      fault_clear && !(|evt_set) |=> evt_flags == 8'h00)
      else $error("fault read did not clear");
   set_wins_a: assert property (@(posedge clk) disable iff (!rst_n)
      fault_clear && pri_under[0] |=> pri_flags[0])
      else $error("fault lost on clearing read");
   pri_set_a: assert property (@(posedge clk) disable iff (!rst_n)
      pri_under[2] |=> pri_flags[2] && !pri_flags[7] && !pri_flags[6])
      else $error("primary flag missing");
   sec_dir_a: assert property (@(posedge clk) disable iff (!rst_n)
      thresh_cfg[1] && sec_over[1] |=> sec_flags[1])
      else $error("overvoltage flag missing");
   mr_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
      manual_reset_input |=> evt_flags[6] && !evt_flags[7])
      else $error("manual reset flag missing");
   wd_both_a: assert property (@(posedge clk) disable iff (!rst_n)
      wd_gen_hit[0] && watchdog_pulse_input_sel == 2'(0) |=> evt_flags[0] && evt_flags[2])
      else $error("watchdog general pair missing");
   lock_write_a: assert property (@(posedge clk) disable iff (!rst_n)
      wr_acc && hit(pa, ffcl_pkg::ADDR_CFG_LOCK) |=> cfg_locked == $past(pwdata[0]))
      else $error("lock bit not written");
   ee_block_a: assert property (@(posedge clk) disable iff (!rst_n)
      ee_wr_req && (|(wr_disable & programmable_output)) |=> !ee_wr_en && ee_wr_blocked)
      else $error("EEPROM write not blocked");
   ee_pass_a: assert property (@(posedge clk) disable iff (!rst_n)
      ee_wr_req && !cfg_locked && !(|(wr_disable & programmable_output)) |=> ee_wr_en && !ee_wr_blocked)
      else $error("EEPROM write wrongly blocked");
   block_report_a: assert property (@(posedge clk) disable iff (!rst_n)
      ee_wr_req && (|(wr_disable & programmable_output)) |=> irq_stat[ffcl_pkg::IRQ_BLOCK_BIT])
      else $error("blocked write not reported");
   unlock_write_a: assert property (@(posedge clk) disable iff (!rst_n)
      !cfg_locked && wr_acc && hit(pa, ffcl_pkg::ADDR_THRESH_CFG) |=> thresh_cfg == $past(pwdata[7:0]))
      else $error("unlocked config write lost");
   pri_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
      fault_clear && !(|pri_set) |=> pri_flags == 8'h00)
      else $error("primary flags not cleared");
   first_read_a: assert property (@(posedge clk) disable iff (!rst_n)
      fault_clear |=> first_read_done)
      else $error("first fault read not recorded");
   sec_under_a: assert property (@(posedge clk) disable iff (!rst_n)
      !thresh_cfg[1] && sec_under[1] |=> sec_flags[1])
      else $error("undervoltage flag missing");
   gen_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
      general_input[2] |=> evt_flags[4])
      else $error("general input flag missing");
   wd_sel_a: assert property (@(posedge clk) disable iff (!rst_n)
      wd_gen_hit[0] && watchdog_pulse_input_sel == 2'(1) |=> evt_flags[0] && evt_flags[3])
      else $error("selected general input not flagged");
endmodule : ffcl_top

// *** tb/ffcl_apb_host.sv ***
// Host model issuing APB transfers to the register block
`timescale 1ns/10ps
module ffcl_apb_host (
   input  wire logic        clk,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic      [9:0]  paddr,
   output logic      [31:0] pwdata,
   input  wire logic        pready
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 10'h000;
      pwdata = 32'h0000_0000;
   end
   ////////////////////////////////////////////////////////////
   // One transfer; bus lines show inverted junk once released
   task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
      pwrite  <= ~pwrite;
      paddr   <= ~paddr;
      pwdata  <= ~pwdata;
   endtask : xfer
endmodule : ffcl_apb_host

// *** tb/test_fault_flags_and_config_lock.sv ***
// Self-checking bench for the fault flag and config lock block
`timescale 1ns/10ps
module test_fault_flags_and_config_lock;
   logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, irq;
   logic [7:0]  thresh_cfg, wr_disable, programmable_output, t, w;
   logic [9:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic [5:0]  pri_under, sec_under, sec_over;
   logic [1:0]  watchdog_timeout, watchdog_pulse_input_sel, watchdog_on_general;
   logic [3:0]  general_input;
   logic        manual_reset_input, ee_wr_req, ee_wr_en, ee_wr_blocked, cfg_locked;
   logic [33:0] notes[$];
   logic [33:0] cur;
   int          miscompares = 0;
   int          checked = 0;
   int          ks[6] = '{1, 2, 1, 3, 4, 5};
   int          vs[6] = '{1, 1, 2, 1, 1, 4};
   int          es[6] = '{0, 1, 1, 1, 5, 1};
   int          fe[6] = '{0, 1, 2, 64, 9, 16};
   logic [7:0]  fa[6] = '{ffcl_pkg::ADDR_SEC_FAULT, ffcl_pkg::ADDR_SEC_FAULT, ffcl_pkg::ADDR_SEC_FAULT,
                         ffcl_pkg::ADDR_EVT_FAULT, ffcl_pkg::ADDR_EVT_FAULT, ffcl_pkg::ADDR_EVT_FAULT};

   ffcl_apb_host u_host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready));
   ffcl_top u_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pri_under(pri_under), .sec_under(sec_under), .sec_over(sec_over),
      .watchdog_timeout(watchdog_timeout), .watchdog_pulse_input_sel(watchdog_pulse_input_sel),
      .watchdog_on_general(watchdog_on_general), .general_input(general_input),
      .manual_reset_input(manual_reset_input), .programmable_output(programmable_output),
      .ee_wr_req(ee_wr_req), .ee_wr_en(ee_wr_en), .ee_wr_blocked(ee_wr_blocked),
      .cfg_locked(cfg_locked), .thresh_cfg(thresh_cfg), .wr_disable(wr_disable), .irq(irq));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic test_done();
      $display("checks %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : test_done
   // Note the expected answer, then run the transfer
   task automatic op(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic cd,
                     input logic err);
      notes.push_back({cd, err, d});
      u_host.xfer(wr, {a, 2'b00}, d);
   endtask : op
   task automatic fire(input int k, input logic [5:0] v);
      @(posedge clk);
      case (k)
         0: pri_under <= v;
         1: sec_under <= v;
         2: sec_over <= v;
         3: manual_reset_input <= v[0];
         4: watchdog_timeout <= v[1:0];
         default: general_input <= v[3:0];
      endcase
      @(posedge clk);
      {pri_under, sec_under, sec_over} <= 18'h00000;
      {manual_reset_input, watchdog_timeout, general_input} <= 7'h00;
   endtask : fire
   ////////////////////////////////////////////////////////////
   // Result watcher
   always @(posedge clk) begin
      if (psel && penable && pready === 1'b1) begin
         cur = notes.pop_front();
         if (cur[33]) begin
            chk(prdata, cur[31:0]);
            chk({31'h0, pslverr}, {31'h0, cur[32]});
         end
      end
   end
   initial begin
      #(25 * 20000);
      miscompares++;
      test_done();
   end
   ////////////////////////////////////////////////////////////
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {pri_under, sec_under, sec_over, general_input, manual_reset_input} = '0;
      {watchdog_timeout, watchdog_pulse_input_sel, watchdog_on_general} = '0;
      {programmable_output, ee_wr_req} = '0;
      rst_n = 1'b0;
      void'($urandom(39509));
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      #1;
      chk({14'h0, irq, cfg_locked, wr_disable, thresh_cfg}, 32'h0);
      op(0, ffcl_pkg::ADDR_EE_STAT, 32'h0, 1'b1, 1'b0);
      op(0, ffcl_pkg::ADDR_PRI_FAULT, 32'h0, 1'b0, 1'b0);
      op(0, ffcl_pkg::ADDR_EE_STAT, 32'h2, 1'b1, 1'b0);
      for (int i = 0; i < 3; i++) begin
         t = 8'($urandom);
         fire(0, t[5:0]);
         op(0, ffcl_pkg::ADDR_PRI_FAULT, {26'h0, t[5:0]}, 1'b1, 1'b0);
         op(1, ffcl_pkg::ADDR_PRI_FAULT, 32'hFF, 1'b0, 1'b0);
         op(0, ffcl_pkg::ADDR_PRI_FAULT, 32'h0, 1'b1, 1'b0);
      end
      @(posedge clk);
      pri_under <= 6'h04;
      op(0, ffcl_pkg::ADDR_PRI_FAULT, 32'h4, 1'b1, 1'b0);
      pri_under <= 6'h00;
      op(0, ffcl_pkg::ADDR_PRI_FAULT, 32'h4, 1'b1, 1'b0);
      op(0, ffcl_pkg::ADDR_PRI_FAULT, 32'h0, 1'b1, 1'b0);
      $display("fault flag test done");
      t = 8'($urandom);
      op(1, ffcl_pkg::ADDR_THRESH_CFG, {24'h0, t}, 1'b0, 1'b0);
      op(1, ffcl_pkg::ADDR_CFG_LOCK, 32'hFF, 1'b0, 1'b0);
      #1;
      chk({31'h0, cfg_locked}, 32'h1);
      op(1, ffcl_pkg::ADDR_THRESH_CFG, {24'h0, ~t}, 1'b0, 1'b0);
      op(1, ffcl_pkg::ADDR_WR_DISABLE, 32'hFF, 1'b0, 1'b0);
      op(1, 8'h20, 32'h5A, 1'b0, 1'b0);
      op(0, 8'h20, 32'h0, 1'b1, 1'b1);
      op(0, ffcl_pkg::ADDR_THRESH_CFG, {24'h0, t}, 1'b1, 1'b0);
      op(0, ffcl_pkg::ADDR_WR_DISABLE, 32'h0, 1'b1, 1'b0);
      op(0, ffcl_pkg::ADDR_CFG_LOCK, 32'h1, 1'b1, 1'b0);
      op(1, ffcl_pkg::ADDR_CFG_LOCK, 32'h0, 1'b0, 1'b0);
      op(1, ffcl_pkg::ADDR_THRESH_CFG, {24'h0, ~t}, 1'b0, 1'b0);
      op(0, ffcl_pkg::ADDR_THRESH_CFG, {24'h0, ~t}, 1'b1, 1'b0);
      $display("lock test done");
      op(1, ffcl_pkg::ADDR_THRESH_CFG, 32'h1, 1'b0, 1'b0);
      watchdog_on_general <= 2'b01;
      watchdog_pulse_input_sel <= 2'b01;
      for (int i = 0; i < 6; i++) begin
         op(1, ffcl_pkg::ADDR_IRQ_STAT, 32'h7, 1'b0, 1'b0);
         fire(ks[i], 6'(vs[i]));
         op(0, ffcl_pkg::ADDR_IRQ_STAT, 32'(es[i]), 1'b1, 1'b0);
         op(0, fa[i], 32'(fe[i]), 1'b1, 1'b0);
      end
      chk({31'h0, irq}, 32'h0);
      op(1, ffcl_pkg::ADDR_IRQ_MASK, 32'h7, 1'b0, 1'b0);
      @(posedge clk);
      #1;
      chk({31'h0, irq}, 32'h1);
      op(1, ffcl_pkg::ADDR_IRQ_STAT, 32'h7, 1'b0, 1'b0);
      @(posedge clk);
      #1;
      chk({31'h0, irq}, 32'h0);
      $display("event test done");
      w = (8'($urandom) | 8'h04) & 8'hF7;
      op(1, ffcl_pkg::ADDR_WR_DISABLE, {24'h0, w}, 1'b0, 1'b0);
      ee_wr_req <= 1'b1;
      for (int n = 0; n < 8; n++) begin
         programmable_output <= 8'h01 << n;
         repeat (2) @(posedge clk);
         #1;
         chk({30'h0, ee_wr_en, ee_wr_blocked}, w[n] ? 32'h1 : 32'h2);
         @(posedge clk);
      end
      ee_wr_req <= 1'b0;
      op(0, ffcl_pkg::ADDR_IRQ_STAT, 32'h2, 1'b1, 1'b0);
      #1;
      chk({31'h0, irq}, 32'h1);
      $display("write disable test done");
      repeat (3) @(posedge clk);
      test_done();
   end
endmodule : test_fault_flags_and_config_lock
